// ===== hdl/dbl_pkg.sv
package dbl_pkg;

   // Clock and debounce timing
   localparam int unsigned DBL_CLK_HZ       = 25_000_000;
   localparam int unsigned DBL_DELAY_MS     = 10;
   localparam int unsigned DBL_DELAY_CYCLES = DBL_CLK_HZ / 1000 * DBL_DELAY_MS;

   // Bus geometry
   localparam int unsigned DBL_AW   = 8;
   localparam int unsigned DBL_NCFG = 15;

   // Register indexes; byte offset is index times four
   localparam logic [3:0] DBL_IX_ISEL0  = 4'h0;
   localparam logic [3:0] DBL_IX_ISEL1  = 4'h1;
   localparam logic [3:0] DBL_IX_ISEL6  = 4'h2;
   localparam logic [3:0] DBL_IX_TSEL0  = 4'h3;
   localparam logic [3:0] DBL_IX_TSEL1  = 4'h4;
   localparam logic [3:0] DBL_IX_TSEL2  = 4'h5;
   localparam logic [3:0] DBL_IX_TSEL6  = 4'h6;
   localparam logic [3:0] DBL_IX_ROUTE0 = 4'h7;
   localparam logic [3:0] DBL_IX_ROUTE1 = 4'h8;
   localparam logic [3:0] DBL_IX_ROUTE2 = 4'h9;
   localparam logic [3:0] DBL_IX_ROUTE6 = 4'hA;
   localparam logic [3:0] DBL_IX_CTL    = 4'hB;
   localparam logic [3:0] DBL_IX_OSEL0  = 4'hC;
   localparam logic [3:0] DBL_IX_OSEL3  = 4'hD;
   localparam logic [3:0] DBL_IX_TCHSEL = 4'hE;
   localparam logic [3:0] DBL_IX_STATUS = 4'hF;
   localparam logic [7:0] DBL_CFG_RESET = 8'h00;

   // Input line source codes
   localparam logic [7:0] DBL_ISRC_SWITCH = 8'h1B;
   localparam logic [7:0] DBL_ISRC_FF1    = 8'h1D;
   localparam logic [7:0] DBL_ISRC_TM_CH0 = 8'h16;
   localparam logic [7:0] DBL_ISRC_TM_CH1 = 8'h17;
   localparam logic [7:0] DBL_ISRC_TM_CH5 = 8'h18;

   // Link target select: bit 7 inverts, low field picks first or second line of group
   localparam int unsigned DBL_TSEL_INV   = 7;
   localparam logic [1:0]  DBL_TSEL_FIRST = 2'h1;
   localparam logic [1:0]  DBL_TSEL_NEXT  = 2'h2;

   // Link target routing codes
   localparam logic [7:0] DBL_RT_CELL0_IN0 = 8'h01;
   localparam logic [7:0] DBL_RT_CELL0_IN1 = 8'h02;
   localparam logic [7:0] DBL_RT_FF1_D     = 8'h09;
   localparam logic [7:0] DBL_RT_FF1_CLK   = 8'h2F;

   // Block control fields
   localparam int unsigned DBL_CTL_FF1_EN = 7;
   localparam logic [7:0]  DBL_OSEL_FIRST = 8'h01;
   localparam logic [7:0]  DBL_OSEL_LAST  = 8'h08;

   typedef enum logic [1:0] {
      DBL_FN_AND  = 2'b00,
      DBL_FN_OR   = 2'b01,
      DBL_FN_XNOR = 2'b10,
      DBL_FN_XOR  = 2'b11
   } dbl_fn_t;

   typedef enum logic [1:0] {
      DBL_TCH_0 = 2'b00,
      DBL_TCH_1 = 2'b01,
      DBL_TCH_5 = 2'b10
   } dbl_tch_t;

   typedef struct packed {
      logic ch5;
      logic ch1;
      logic ch0;
   } dbl_irq_t;

   typedef struct packed {
      logic timer_busy;
      logic switch_level;
      logic ff1;
      logic cell0;
   } dbl_status_t;

endpackage

// ===== hdl/dbl_sync.sv
`timescale 1ns/1ps
module dbl_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1) begin : g_bad_width
      $error("dbl_sync: WIDTH must be at least 1");
   end

   // First stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // dbl_sync

// ===== hdl/dbl_delay_timer.sv
`timescale 1ns/1ps
module dbl_delay_timer #(
   parameter int unsigned DELAY_CYCLES = 250000
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Trigger input and end of count
   input  wire logic trig_in,
   output logic      end_pulse_q,
   output logic      busy_q
);
   localparam int unsigned CW = $clog2(DELAY_CYCLES + 1);

   logic          trig_prev_q;
   logic [CW-1:0] cnt_q;
   logic          edge_seen;

   if (DELAY_CYCLES < 1) begin : g_bad_delay
      $error("dbl_delay_timer: DELAY_CYCLES must be at least 1");
   end

   assign edge_seen = trig_in ^ trig_prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) trig_prev_q <= 1'b0;
      else trig_prev_q <= trig_in;
   end

   // Either edge starts or restarts the count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q       <= '0;
         busy_q      <= 1'b0;
         end_pulse_q <= 1'b0;
      end else begin
         end_pulse_q <= 1'b0;
         if (edge_seen) begin
            cnt_q  <= CW'(DELAY_CYCLES - 1);
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (cnt_q == '0) begin
               busy_q      <= 1'b0;
               // Falling trigger means input settled back: no event
               end_pulse_q <= trig_in;
            end else begin
               cnt_q <= cnt_q - CW'(1);
            end
         end
      end
   end

   property p_restart;
      @(posedge pclk) disable iff (!presetn)
      edge_seen |=> busy_q && cnt_q == CW'(DELAY_CYCLES - 1);
   endproperty
   a_restart: assert property (p_restart) else $error("edge did not restart count");

   property p_end_cause;
      @(posedge pclk) disable iff (!presetn)
      end_pulse_q |-> $past(busy_q) && $past(cnt_q) == '0 && $past(trig_in);
   endproperty
   a_end_cause: assert property (p_end_cause) else $error("end pulse without expiry");
endmodule // dbl_delay_timer

// ===== hdl/dbl_top.sv
`timescale 1ns/1ps
module dbl_top
   import dbl_pkg::*;
#(
   parameter int unsigned DELAY_CYCLES = dbl_pkg::DBL_DELAY_CYCLES
) (
   // Clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [dbl_pkg::DBL_AW-1:0]  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Pins
   input  wire logic                        switch_input_pin,
   output logic                             debounced_output_pin,
   output logic                             timer_chan_in
);
   import dbl_pkg::*;

   if (DELAY_CYCLES < 1) begin : g_bad_delay
      $error("dbl_top: DELAY_CYCLES must be at least 1");
   end

   logic [7:0]  cfg_q [DBL_NCFG];
   logic        sw_level;
   logic        ff1_q;
   logic        ff_clk_prev_q;
   logic        tmr_end;
   logic        tmr_busy;
   dbl_irq_t    irq;
   logic        line0, line1, line6, line7;
   logic        tgt0, tgt1, tgt2, tgt6;
   logic        cell_in0, cell_in1, ff_d, ff_clk;
   logic        ff_clk_rise;
   logic        cell0;
   logic [7:0]  blk_out;
   logic        setup_phase;
   logic        access_wr;
   logic        addr_ok;
   logic [3:0]  addr_ix;
   logic [31:0] rd_word;
   dbl_status_t status;

   // Input line source decode
   function automatic logic src_line(input logic [7:0] code, input logic sw,
                                     input logic ff, input dbl_irq_t ir);
      logic v;
      v = 1'b0;
      unique case (code)
         DBL_ISRC_SWITCH: v = sw;
         DBL_ISRC_FF1:    v = ff;
         DBL_ISRC_TM_CH0: v = ir.ch0;
         DBL_ISRC_TM_CH1: v = ir.ch1;
         DBL_ISRC_TM_CH5: v = ir.ch5;
         default:         v = 1'b0;
      endcase
      return v;
   endfunction

   // Link target: one of two lines of its group, bit 7 gives negative logic
   function automatic logic pick_target(input logic [7:0] sel, input logic first,
                                        input logic next);
      logic v;
      v = 1'b0;
      if (sel[1:0] == DBL_TSEL_FIRST) v = first ^ sel[DBL_TSEL_INV];
      else if (sel[1:0] == DBL_TSEL_NEXT) v = next ^ sel[DBL_TSEL_INV];
      return v;
   endfunction

   // Any target whose route register holds code drives that destination
   function automatic logic route_hit(input logic [7:0] code, input logic [7:0] r0,
                                      input logic [7:0] r1, input logic [7:0] r2,
                                      input logic [7:0] r6, input logic [3:0] tg);
      return (r0 == code && tg[0]) || (r1 == code && tg[1]) ||
             (r2 == code && tg[2]) || (r6 == code && tg[3]);
   endfunction

   // Output selector: code n picks block output n-1, zero turns off
   function automatic logic out_pick(input logic [7:0] sel, input logic [7:0] blk);
      logic [7:0] ix;
      ix = sel - DBL_OSEL_FIRST;
      if (sel >= DBL_OSEL_FIRST && sel <= DBL_OSEL_LAST) return blk[ix[2:0]];
      return 1'b0;
   endfunction

   function automatic logic cell_fn(input logic [1:0] fn, input logic a, input logic b);
      logic v;
      v = 1'b0;
      unique case (dbl_fn_t'(fn))
         DBL_FN_AND:  v = a & b;
         DBL_FN_OR:   v = a | b;
         DBL_FN_XNOR: v = ~(a ^ b);
         DBL_FN_XOR:  v = a ^ b;
      endcase
      return v;
   endfunction

   // Switch pin is asynchronous to pclk
   dbl_sync #(
      .WIDTH (1)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (switch_input_pin),
      .sync_out (sw_level)
   );

   dbl_delay_timer #(
      .DELAY_CYCLES (DELAY_CYCLES)
   ) u_timer (
      .pclk        (pclk),
      .presetn     (presetn),
      .trig_in     (timer_chan_in),
      .end_pulse_q (tmr_end),
      .busy_q      (tmr_busy)
   );

   // End of count appears only on the channel in use
   always_comb begin
      irq     = '0;
      unique case (cfg_q[DBL_IX_TCHSEL][1:0])
         DBL_TCH_0: irq.ch0 = tmr_end;
         DBL_TCH_1: irq.ch1 = tmr_end;
         DBL_TCH_5: irq.ch5 = tmr_end;
         default:   irq     = '0;
      endcase
   end

   // Input lines
   assign line0 = src_line(cfg_q[DBL_IX_ISEL0], sw_level, ff1_q, irq);
   assign line1 = src_line(cfg_q[DBL_IX_ISEL1], sw_level, ff1_q, irq);
   assign line6 = src_line(cfg_q[DBL_IX_ISEL6], sw_level, ff1_q, irq);
   assign line7 = 1'b0;

   // Link targets of the block
   assign tgt0 = pick_target(cfg_q[DBL_IX_TSEL0], line0, line1);
   assign tgt1 = pick_target(cfg_q[DBL_IX_TSEL1], line0, line1);
   assign tgt2 = pick_target(cfg_q[DBL_IX_TSEL2], line0, line1);
   assign tgt6 = pick_target(cfg_q[DBL_IX_TSEL6], line6, line7);

   // Target routing into cell and flip-flop
   assign cell_in0 = route_hit(DBL_RT_CELL0_IN0, cfg_q[DBL_IX_ROUTE0], cfg_q[DBL_IX_ROUTE1],
                               cfg_q[DBL_IX_ROUTE2], cfg_q[DBL_IX_ROUTE6],
                               {tgt6, tgt2, tgt1, tgt0});
   assign cell_in1 = route_hit(DBL_RT_CELL0_IN1, cfg_q[DBL_IX_ROUTE0], cfg_q[DBL_IX_ROUTE1],
                               cfg_q[DBL_IX_ROUTE2], cfg_q[DBL_IX_ROUTE6],
                               {tgt6, tgt2, tgt1, tgt0});
   assign ff_d     = route_hit(DBL_RT_FF1_D, cfg_q[DBL_IX_ROUTE0], cfg_q[DBL_IX_ROUTE1],
                               cfg_q[DBL_IX_ROUTE2], cfg_q[DBL_IX_ROUTE6],
                               {tgt6, tgt2, tgt1, tgt0});
   assign ff_clk   = route_hit(DBL_RT_FF1_CLK, cfg_q[DBL_IX_ROUTE0], cfg_q[DBL_IX_ROUTE1],
                               cfg_q[DBL_IX_ROUTE2], cfg_q[DBL_IX_ROUTE6],
                               {tgt6, tgt2, tgt1, tgt0});

   assign cell0 = cell_fn(cfg_q[DBL_IX_CTL][1:0], cell_in0, cell_in1);

   // Block outputs: [0] cell 0, [4] flip-flop 1, rest unused here
   assign blk_out = {3'b000, ff1_q, 3'b000, cell0};

   // Flip-flop clock is an edge of the routed level, kept in the pclk domain
   assign ff_clk_rise = ff_clk & ~ff_clk_prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ff_clk_prev_q <= 1'b0;
      else ff_clk_prev_q <= ff_clk;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ff1_q <= 1'b0;
      else if (!cfg_q[DBL_IX_CTL][DBL_CTL_FF1_EN]) ff1_q <= 1'b0;
      else if (ff_clk_rise) ff1_q <= ff_d;
   end

   // Pins and timer input leave from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         debounced_output_pin <= 1'b0;
         timer_chan_in        <= 1'b0;
      end else begin
         debounced_output_pin <= out_pick(cfg_q[DBL_IX_OSEL0], blk_out);
         timer_chan_in        <= out_pick(cfg_q[DBL_IX_OSEL3], blk_out);
      end
   end

   // APB decode; one wait-free access phase, pready from a flop
   assign setup_phase = psel & ~penable;
   assign addr_ix     = paddr[5:2];
   assign addr_ok     = (paddr[DBL_AW-1:6] == '0) && (paddr[1:0] == 2'b00);
   assign access_wr   = psel & penable & pready & pwrite & addr_ok &
                        (addr_ix != DBL_IX_STATUS);

   assign status = '{timer_busy: tmr_busy, switch_level: sw_level, ff1: ff1_q, cell0: cell0};

   always_comb begin
      rd_word = '0;
      if (addr_ok) begin
         if (addr_ix == DBL_IX_STATUS) rd_word = 32'(status);
         else rd_word = {24'h000000, cfg_q[addr_ix]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= setup_phase;
         pslverr <= setup_phase & ~addr_ok;
         if (setup_phase && !pwrite) prdata <= rd_word;
      end
   end

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DBL_NCFG; i++) cfg_q[i] <= DBL_CFG_RESET;
      end else if (access_wr) begin
         cfg_q[addr_ix] <= pwdata[7:0];
      end
   end

   // Checks
   property p_ff_only_on_clock;
      @(posedge pclk) disable iff (!presetn)
      $rose(ff1_q) |-> $past(ff_clk_rise);
   endproperty
   a_ff_only_on_clock: assert property (p_ff_only_on_clock) else $error("ff1 set without clock");

   property p_irq_channel;
      @(posedge pclk) disable iff (!presetn)
      tmr_end && cfg_q[DBL_IX_TCHSEL][1:0] == DBL_TCH_0 && cfg_q[DBL_IX_ISEL6] == DBL_ISRC_TM_CH0
      |-> line6 && !irq.ch1 && !irq.ch5;
   endproperty
   a_irq_channel: assert property (p_irq_channel) else $error("channel 0 irq not on line 6");

   property p_switch_line;
      @(posedge pclk) disable iff (!presetn)
      cfg_q[DBL_IX_ISEL0] == DBL_ISRC_SWITCH && cfg_q[DBL_IX_TSEL0] == 8'h01 |-> tgt0 == sw_level;
   endproperty
   a_switch_line: assert property (p_switch_line) else $error("switch not on target 0");

   property p_inverted_target;
      @(posedge pclk) disable iff (!presetn)
      cfg_q[DBL_IX_ISEL1] == DBL_ISRC_FF1 && cfg_q[DBL_IX_TSEL2] == 8'h82 |-> tgt2 == !ff1_q;
   endproperty
   a_inverted_target: assert property (p_inverted_target) else $error("target 2 not inverted");

   property p_data_route;
      @(posedge pclk) disable iff (!presetn)
      cfg_q[DBL_IX_ROUTE2] == DBL_RT_FF1_D && cfg_q[DBL_IX_ROUTE0] != DBL_RT_FF1_D &&
      cfg_q[DBL_IX_ROUTE1] != DBL_RT_FF1_D && cfg_q[DBL_IX_ROUTE6] != DBL_RT_FF1_D
      |-> ff_d == tgt2;
   endproperty
   a_data_route: assert property (p_data_route) else $error("ff1 data not from target 2");

   property p_xor_cell;
      @(posedge pclk) disable iff (!presetn)
      cfg_q[DBL_IX_CTL] == 8'h83 |-> cell0 == (cell_in0 ^ cell_in1);
   endproperty
   a_xor_cell: assert property (p_xor_cell) else $error("cell 0 not exclusive-or");

   property p_output_pin;
      @(posedge pclk) disable iff (!presetn)
      cfg_q[DBL_IX_OSEL0] == 8'h05 ##1 cfg_q[DBL_IX_OSEL0] == 8'h05
      |-> debounced_output_pin == $past(ff1_q);
   endproperty
   a_output_pin: assert property (p_output_pin) else $error("pin does not follow ff1");

   property p_timer_input;
      @(posedge pclk) disable iff (!presetn)
      cfg_q[DBL_IX_OSEL3] == 8'h01 ##1 cfg_q[DBL_IX_OSEL3] == 8'h01
      |-> timer_chan_in == $past(cell0);
   endproperty
   a_timer_input: assert property (p_timer_input) else $error("timer input not cell 0");

   property p_target0_route;
      @(posedge pclk) disable iff (!presetn)
      cfg_q[DBL_IX_ROUTE0] == DBL_RT_CELL0_IN0 && tgt0 |-> cell_in0;
   endproperty
   a_target0_route: assert property (p_target0_route) else $error("target 0 not on input 0");

   property p_target6_clock;
      @(posedge pclk) disable iff (!presetn)
      cfg_q[DBL_IX_TSEL6] == 8'h01 && cfg_q[DBL_IX_ROUTE6] == DBL_RT_FF1_CLK && line6 |-> ff_clk;
   endproperty
   a_target6_clock: assert property (p_target6_clock) else $error("line 6 not clocking ff1");

   property p_ff_takes_data;
      @(posedge pclk) disable iff (!presetn)
      ff_clk_rise && cfg_q[DBL_IX_CTL][DBL_CTL_FF1_EN] |=> ff1_q == $past(ff_d);
   endproperty
   a_ff_takes_data: assert property (p_ff_takes_data) else $error("ff1 did not load data");

   property p_ff_disabled;
      @(posedge pclk) disable iff (!presetn)
      !cfg_q[DBL_IX_CTL][DBL_CTL_FF1_EN] |=> !ff1_q;
   endproperty
   a_ff_disabled: assert property (p_ff_disabled) else $error("ff1 not held clear");

   property p_channel5_irq;
      @(posedge pclk) disable iff (!presetn)
      tmr_end && cfg_q[DBL_IX_TCHSEL][1:0] == DBL_TCH_5 |-> irq.ch5 && !irq.ch0 && !irq.ch1;
   endproperty
   a_channel5_irq: assert property (p_channel5_irq) else $error("channel 5 irq misrouted");

   property p_target1_line;
      @(posedge pclk) disable iff (!presetn)
      cfg_q[DBL_IX_ISEL1] == DBL_ISRC_FF1 && cfg_q[DBL_IX_TSEL1] == 8'h02 |-> tgt1 == ff1_q;
   endproperty
   a_target1_line: assert property (p_target1_line) else $error("ff1 not on target 1");

   property p_unmapped_err;
      @(posedge pclk) disable iff (!presetn)
      setup_phase && !addr_ok |=> pready && pslverr;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access without error");

   property p_apb_ready;
      @(posedge pclk) disable iff (!presetn)
      setup_phase |=> pready ##1 !pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("pready not one cycle after setup");

endmodule // dbl_top

// ===== verif/dbl_switch_model.sv
`timescale 1ns/1ps
module dbl_switch_model (
   // Clock
   input  wire logic pclk,
   // Contact level
   output logic      switch_input_pin
);
   initial switch_input_pin = 1'b0;

   // Moves just after an edge; contact has no notion of the block clock otherwise
   task automatic settle(input logic lvl);
      @(posedge pclk);
      switch_input_pin <= lvl;
   endtask

   // Chatter gap kept below the debounce delay so no bounce survives
   task automatic chatter(input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         repeat (gap) @(posedge pclk);
         switch_input_pin <= ~switch_input_pin;
      end
   endtask
endmodule // dbl_switch_model

// ===== verif/dbl_top_tb.sv
`timescale 1ns/1ps
module dbl_top_tb;
   import dbl_pkg::*;
   localparam int unsigned D     = 16;
   localparam int          LIMIT = 10000;
   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [DBL_AW-1:0] paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              switch_input_pin;
   logic              debounced_output_pin;
   logic              timer_chan_in;
   int                n_fail;
   int                cmp_count;
   int                cyc;
   logic [3:0]        cfg_ix [15];
   logic [7:0]        cfg_val [15];
   logic [3:0]        bad_ix [4];
   logic [7:0]        bad_val [4];
   logic [7:0]        good_val [4];
   logic [7:0]        ch_src [3];
   logic [3:0]        fn_exp;

   dbl_top #(.DELAY_CYCLES(D)) i_dbl_top (
      .pclk                 (pclk),
      .presetn              (presetn),
      .psel                 (psel),
      .penable              (penable),
      .pwrite               (pwrite),
      .paddr                (paddr),
      .pwdata               (pwdata),
      .prdata               (prdata),
      .pready               (pready),
      .pslverr              (pslverr),
      .switch_input_pin     (switch_input_pin),
      .debounced_output_pin (debounced_output_pin),
      .timer_chan_in        (timer_chan_in)
   );

   dbl_switch_model i_dbl_switch_model (
      .pclk             (pclk),
      .switch_input_pin (switch_input_pin)
   );

   always #20 pclk = ~pclk;

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_fail++;
         $display("Error at %0t ns: run did not finish in time", $time);
         tally_and_finish();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_test(input string name);
      $display("Test %s done, %0d mismatches so far", name, n_fail);
   endtask

   // Held from setup until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wdat,
                      output logic [31:0] rdat, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= {24'h0, wdat};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk iff pready);
      rdat = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [7:0] adr(input logic [3:0] ix);
      return {2'b00, ix, 2'b00};
   endfunction

   task automatic wr(input logic [3:0] ix, input logic [7:0] val);
      logic [31:0] d;
      logic        e;
      apb(1'b1, adr(ix), val, d, e);
      check({31'h0, e}, 32'h0);
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input logic exp_err);
      logic [31:0] d;
      logic        e;
      apb(1'b0, addr, 8'h00, d, e);
      check(d, {24'h0, exp});
      check({31'h0, e}, {31'h0, exp_err});
   endtask

   // Moves the switch and checks the delay path; moves=0 means output must hold
   task automatic follow(input logic lvl, input logic moves);
      logic prev;
      prev = debounced_output_pin;
      i_dbl_switch_model.settle(lvl);
      repeat (4) @(posedge pclk);
      check({31'h0, timer_chan_in}, {31'h0, lvl ^ prev});
      repeat (D - 6) @(posedge pclk);
      check({31'h0, debounced_output_pin}, {31'h0, prev});
      for (int k = 0; k < 20 && (!moves || debounced_output_pin !== lvl); k++) begin
         @(posedge pclk);
      end
      check({31'h0, debounced_output_pin}, {31'h0, moves ? lvl : prev});
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      n_fail = 0;
      cmp_count = 0;
      cyc = 0;
      // Switch source never doubles as the output destination
      cfg_ix = '{DBL_IX_ISEL0, DBL_IX_ISEL1, DBL_IX_ISEL6, DBL_IX_TSEL0, DBL_IX_TSEL1,
                 DBL_IX_TSEL2, DBL_IX_TSEL6, DBL_IX_ROUTE0, DBL_IX_ROUTE1, DBL_IX_ROUTE2,
                 DBL_IX_ROUTE6, DBL_IX_CTL, DBL_IX_OSEL0, DBL_IX_OSEL3, DBL_IX_TCHSEL};
      cfg_val = '{8'h1B, 8'h1D, 8'h16, 8'h01, 8'h02, 8'h82, 8'h01, 8'h01, 8'h02, 8'h09,
                  8'h2F, 8'h83, 8'h05, 8'h01, 8'h00};
      bad_ix = '{DBL_IX_ISEL6, DBL_IX_TSEL2, DBL_IX_ROUTE6, DBL_IX_CTL};
      bad_val = '{8'h17, 8'h02, 8'h00, 8'h03};
      good_val = '{8'h16, 8'h82, 8'h2F, 8'h83};
      ch_src = '{DBL_ISRC_TM_CH0, DBL_ISRC_TM_CH1, DBL_ISRC_TM_CH5};
      fn_exp = 4'b0100;
      repeat (6) @(posedge pclk);
      check({31'h0, debounced_output_pin}, 32'h0);
      check({31'h0, timer_chan_in}, 32'h0);
      presetn <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         rd_chk(adr(i[3:0]), DBL_CFG_RESET, 1'b0);
      end
      end_test("reset");

      for (int i = 0; i < 15; i++) begin
         wr(cfg_ix[i], cfg_val[i]);
      end
      for (int i = 0; i < 15; i++) begin
         rd_chk(adr(cfg_ix[i]), cfg_val[i], 1'b0);
      end
      wr(DBL_IX_STATUS, 8'hFF);
      rd_chk(adr(DBL_IX_STATUS), 8'h00, 1'b0);
      rd_chk(8'h40, 8'h00, 1'b1);
      rd_chk(8'h01, 8'h00, 1'b1);
      rd_chk(adr(DBL_IX_ISEL0), DBL_ISRC_SWITCH, 1'b0);
      end_test("registers");

      follow(1'b1, 1'b1);
      follow(1'b0, 1'b1);
      i_dbl_switch_model.chatter(7, 5);
      check({31'h0, debounced_output_pin}, 32'h0);
      follow(1'b1, 1'b1);
      i_dbl_switch_model.settle(1'b0);
      repeat (8) @(posedge pclk);
      follow(1'b1, 1'b0);
      follow(1'b0, 1'b1);
      end_test("debounce");

      for (int f = 0; f < 4; f++) begin
         wr(DBL_IX_CTL, 8'h80 | f[7:0]);
         repeat (3) @(posedge pclk);
         check({31'h0, timer_chan_in}, {31'h0, fn_exp[f]});
      end
      wr(DBL_IX_CTL, 8'h83);
      repeat (D + 20) @(posedge pclk);
      check({31'h0, debounced_output_pin}, 32'h0);
      end_test("cell function");

      for (int c = 0; c < 3; c++) begin
         wr(DBL_IX_ISEL6, ch_src[c]);
         wr(DBL_IX_TCHSEL, c[7:0]);
         follow(1'b1, 1'b1);
         follow(1'b0, 1'b1);
      end
      wr(DBL_IX_ISEL6, DBL_ISRC_TM_CH0);
      wr(DBL_IX_TCHSEL, 8'h00);
      end_test("timer channels");

      for (int b = 0; b < 4; b++) begin
         wr(bad_ix[b], bad_val[b]);
         follow(1'b1, 1'b0);
         follow(1'b0, 1'b0);
         wr(bad_ix[b], good_val[b]);
      end
      follow(1'b1, 1'b1);
      // Flip-flop toggle drops the timer input, so the timer restarts and shows busy
      rd_chk(adr(DBL_IX_STATUS), 8'h0E, 1'b0);
      end_test("broken links");
      tally_and_finish();
   end
endmodule // dbl_top_tb
